// >>> hw/ocp_regs.vh
`ifndef OCP_REGS_VH
`define OCP_REGS_VH

// register select line values
`define OCP_SEL_COMMAND 1'b0
`define OCP_SEL_MASK 1'b1

// command byte field positions
`define OCP_BIT_ROTATE 7
`define OCP_BIT_LEVEL_SELECT 6
`define OCP_BIT_END_OF_SERVICE 5
`define OCP_BIT_KIND_HI 4
`define OCP_BIT_KIND_LO 3
`define OCP_LEVEL_HI 2
`define OCP_LEVEL_LO 0
`define OCP_BIT_SPECIAL_GATE 6
`define OCP_BIT_SPECIAL_SET 5
`define OCP_BIT_POLL 2
`define OCP_BIT_READ_REQUEST 1
`define OCP_BIT_IS_CHOICE 0

// command kind codes in bits 4:3
`define OCP_KIND_ROTATE_EOS 2'h0
`define OCP_KIND_SPECIAL_POLL 2'h1

// rotate / level select / end-of-service action codes (bits 7:5)
`define OCP_ACT_AUTO_ROT_CLR 3'h0
`define OCP_ACT_NONSPEC_EOS 3'h1
`define OCP_ACT_NOP 3'h2
`define OCP_ACT_SPEC_EOS 3'h3
`define OCP_ACT_AUTO_ROT_SET 3'h4
`define OCP_ACT_ROT_NONSPEC 3'h5
`define OCP_ACT_SET_PRIO 3'h6
`define OCP_ACT_ROT_SPEC 3'h7

// reset values
`define OCP_MASK_RESET 8'h00
`define OCP_LOWEST_RESET 3'h7
`define OCP_SPURIOUS_LEVEL 3'h7

`endif

// >>> hw/ocp_core.v
// What this block does
// - after initialization, take requests and accept run-time command words
// - byte written with select high loads all eight mask bits, bit n for input n
// - mask one inhibits its channel, mask zero leaves it enabled
// - select low, bits 4:3 zero: rotate, level select, end-of-service flags choose action
// - bits 2:0 give the level acted upon, used only with level select set
// - select low, bit7 0, bits 4:3 = 01: special mask, poll and read fields
// - gate one: special mask setting one enters, zero leaves special mask mode
// - gate zero: setting ignored, mask mode unchanged
// - fully nested mode after initialization unless reprogrammed
// - levels 0..7, input 0 highest and 7 lowest after initialization
// - acknowledge resolves highest pending request, drives its vector, sets in-service bit
// - in-service bit holds until end-of-service, or ack trailing edge in auto mode
// - set in-service bit blocks same and lower levels (only its own level in special mask mode), higher ones still interrupt
// - priority order changeable by rotation or set-priority command
// - flags eos=1, sl=0, r=0 form a non-specific end-of-service
// - non-specific end-of-service clears the highest-priority in-service bit, skipping masked ones in special mask mode
// - flags eos=1, sl=1, r=0 clear the in-service bit named by the level field
`timescale 1ns/10ps
`default_nettype none
`include "ocp_regs.vh"

module ocp_core #(
	parameter NUM_LEVELS = 8
) (
	input wire CLOCK,
	input wire RST,
	input wire INIT_DONE,
	input wire AUTO_SERVICE_END,
	input wire [4:0] VECTOR_BASE,
	input wire CS_N,
	input wire WR_N,
	input wire RD_N,
	input wire REG_SEL,
	input wire [7:0] DATA_IN,
	input wire ACK_N,
	input wire [NUM_LEVELS-1:0] REQ,
	output reg [7:0] DATA_OUT,
	output reg DATA_OE_N,
	output reg INT,
	output reg [NUM_LEVELS-1:0] MASK_OUT,
	output reg [NUM_LEVELS-1:0] IN_SERVICE_OUT,
	output reg SPECIAL_MASK_OUT,
	output reg [2:0] LOWEST_LEVEL_OUT
);

	// acknowledge sequence states
	localparam ST_IDLE = 2'h0;
	localparam ST_FIRST = 2'h1;
	localparam ST_GAP = 2'h2;
	localparam ST_SECOND = 2'h3;

	// highest-priority set bit of v when low is the lowest level: {found, level}
	function [3:0] ocp_pick;
		input [7:0] v;
		input [2:0] low;
		integer i;
		reg [2:0] k;
		begin
			ocp_pick = 4'h0;
			// walk from lowest to highest so the highest set bit is left last
			for (i = 8; i >= 1; i = i - 1) begin
				k = low + i[2:0];
				if (v[k])
					ocp_pick = {1'b1, k};
			end
		end
	endfunction

	// rank of a level, zero is the highest priority
	function [2:0] ocp_rank;
		input [2:0] lvl;
		input [2:0] low;
		begin
			ocp_rank = lvl - low - 3'h1;
		end
	endfunction

	reg wr_act_q;
	reg [7:0] wr_data_q;
	reg wr_sel_q;
	reg rd_act_q;
	reg ack_n_q;
	reg [1:0] ack_st_q, ack_st_d;
	reg [2:0] ack_lvl_q, ack_lvl_d;
	reg [7:0] mask_q, mask_d;
	reg [7:0] isr_q, isr_d;
	reg [7:0] irr_q;
	reg [2:0] low_q, low_d;
	reg smm_q, smm_d;
	reg auto_rot_q, auto_rot_d;
	reg poll_q, poll_d;
	reg read_is_q, read_is_d;
	reg [7:0] dout_d;
	reg oe_n_d;
	reg int_d;

	reg [7:0] pending;
	reg [7:0] eligible;
	reg [3:0] cand;
	reg [3:0] top_is;
	reg [3:0] top_clr;
	reg [7:0] isr_set, isr_clr;
	reg [2:0] act;
	reg [2:0] lvl;
	integer j;

	wire wr_act = ~CS_N & ~WR_N;
	wire wr_end = wr_act_q & ~wr_act;
	wire rd_act = ~CS_N & ~RD_N;
	wire rd_start = rd_act & ~rd_act_q;
	wire ack_fall = ack_n_q & ~ACK_N;
	wire ack_rise = ~ack_n_q & ACK_N;
	wire cmd_is_mask = wr_end & (wr_sel_q == `OCP_SEL_MASK);
	wire cmd_is_rot = wr_end & (wr_sel_q == `OCP_SEL_COMMAND) &
		(wr_data_q[`OCP_BIT_KIND_HI:`OCP_BIT_KIND_LO] == `OCP_KIND_ROTATE_EOS);
	wire cmd_is_spc = wr_end & (wr_sel_q == `OCP_SEL_COMMAND) & ~wr_data_q[`OCP_BIT_ROTATE] &
		(wr_data_q[`OCP_BIT_KIND_HI:`OCP_BIT_KIND_LO] == `OCP_KIND_SPECIAL_POLL);

	// capture byte and select during the strobe; decoding waits for its end
	always @(posedge CLOCK) begin
		if (RST) begin
			wr_act_q <= 1'b0;
			wr_data_q <= 8'h00;
			wr_sel_q <= 1'b0;
			rd_act_q <= 1'b0;
			ack_n_q <= 1'b1;
			irr_q <= 8'h00;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			ack_n_q <= ACK_N;
			irr_q <= REQ[7:0];
			if (wr_act) begin
				wr_data_q <= DATA_IN;
				wr_sel_q <= REG_SEL;
			end
		end
	end

	// priority resolution and command decoding
	always @* begin
		mask_d = mask_q;
		low_d = low_q;
		smm_d = smm_q;
		auto_rot_d = auto_rot_q;
		poll_d = poll_q;
		read_is_d = read_is_q;
		ack_st_d = ack_st_q;
		ack_lvl_d = ack_lvl_q;
		dout_d = DATA_OUT;
		oe_n_d = 1'b1;
		isr_set = 8'h00;
		isr_clr = 8'h00;
		act = wr_data_q[`OCP_BIT_ROTATE:`OCP_BIT_END_OF_SERVICE];
		lvl = wr_data_q[`OCP_LEVEL_HI:`OCP_LEVEL_LO];

		// masked channels never take part
		pending = irr_q & ~mask_q;
		top_is = ocp_pick(isr_q, low_q);
		eligible = 8'h00;
		for (j = 0; j < 8; j = j + 1) begin
			if (smm_q)
				eligible[j] = pending[j] & ~isr_q[j];
			else if (!top_is[3] || ocp_rank(j[2:0], low_q) < ocp_rank(top_is[2:0], low_q))
				eligible[j] = pending[j];
		end
		cand = ocp_pick(eligible, low_q);
		int_d = INIT_DONE & cand[3];

		// in special mask mode, masked in-service levels survive a non-specific end
		top_clr = ocp_pick(isr_q & ~(smm_q ? mask_q : 8'h00), low_q);

		// two-pulse acknowledge: freeze on the first, vector on the second
		case (ack_st_q)
			ST_IDLE: begin
				if (ack_fall && INIT_DONE) begin
					ack_st_d = ST_FIRST;
					ack_lvl_d = cand[3] ? cand[2:0] : `OCP_SPURIOUS_LEVEL;
					if (cand[3])
						isr_set[cand[2:0]] = 1'b1;
				end
			end
			ST_FIRST: begin
				if (ack_rise)
					ack_st_d = ST_GAP;
			end
			ST_GAP: begin
				if (ack_fall)
					ack_st_d = ST_SECOND;
			end
			ST_SECOND: begin
				oe_n_d = 1'b0;
				dout_d = {VECTOR_BASE, ack_lvl_q};
				if (ack_rise) begin
					ack_st_d = ST_IDLE;
					oe_n_d = 1'b1;
					// automatic end clears at the trailing edge of the final pulse
					if (AUTO_SERVICE_END && top_clr[3]) begin
						isr_clr[top_clr[2:0]] = 1'b1;
						if (auto_rot_q)
							low_d = top_clr[2:0];
					end
				end
			end
			default: begin
				ack_st_d = ST_IDLE;
			end
		endcase

		// register reads; poll answers with the top request and services it
		if (rd_act && ack_st_q != ST_SECOND) begin
			oe_n_d = 1'b0;
			if (REG_SEL == `OCP_SEL_MASK)
				dout_d = mask_q;
			else if (poll_q) begin
				if (rd_start) begin
					dout_d = {cand[3], 4'h0, cand[2:0]};
					if (cand[3])
						isr_set[cand[2:0]] = 1'b1;
					poll_d = 1'b0;
				end
			end else if (rd_start)
				// status frozen at read start so the byte stands for the whole strobe
				dout_d = read_is_q ? isr_q : irr_q;
		end

		// commands only after initialization
		if (INIT_DONE) begin
			if (cmd_is_mask)
				mask_d = wr_data_q;
			if (cmd_is_rot) begin
				case (act)
					`OCP_ACT_NONSPEC_EOS: begin
						if (top_clr[3])
							isr_clr[top_clr[2:0]] = 1'b1;
					end
					`OCP_ACT_SPEC_EOS: begin
						isr_clr[lvl] = 1'b1;
					end
					`OCP_ACT_ROT_NONSPEC: begin
						if (top_clr[3]) begin
							isr_clr[top_clr[2:0]] = 1'b1;
							low_d = top_clr[2:0];
						end
					end
					`OCP_ACT_ROT_SPEC: begin
						isr_clr[lvl] = 1'b1;
						low_d = lvl;
					end
					`OCP_ACT_SET_PRIO: begin
						low_d = lvl;
					end
					`OCP_ACT_AUTO_ROT_SET: begin
						auto_rot_d = 1'b1;
					end
					`OCP_ACT_AUTO_ROT_CLR: begin
						auto_rot_d = 1'b0;
					end
					default: begin
						low_d = low_q;
					end
				endcase
			end
			if (cmd_is_spc) begin
				if (wr_data_q[`OCP_BIT_SPECIAL_GATE])
					smm_d = wr_data_q[`OCP_BIT_SPECIAL_SET];
				else
					smm_d = smm_q;
				poll_d = wr_data_q[`OCP_BIT_POLL];
				if (wr_data_q[`OCP_BIT_READ_REQUEST])
					read_is_d = wr_data_q[`OCP_BIT_IS_CHOICE];
			end
		end

		// setting wins over a clear of the same bit in one cycle
		isr_d = (isr_q & ~isr_clr) | isr_set;

		// until initialization is done, hold the nested defaults
		if (!INIT_DONE) begin
			mask_d = `OCP_MASK_RESET;
			low_d = `OCP_LOWEST_RESET;
			smm_d = 1'b0;
			auto_rot_d = 1'b0;
			poll_d = 1'b0;
			read_is_d = 1'b0;
			isr_d = 8'h00;
		end
	end

	// state and output flip-flops
	always @(posedge CLOCK) begin
		if (RST) begin
			mask_q <= `OCP_MASK_RESET;
			isr_q <= 8'h00;
			low_q <= `OCP_LOWEST_RESET;
			smm_q <= 1'b0;
			auto_rot_q <= 1'b0;
			poll_q <= 1'b0;
			read_is_q <= 1'b0;
			ack_st_q <= ST_IDLE;
			ack_lvl_q <= 3'h0;
			DATA_OUT <= 8'h00;
			DATA_OE_N <= 1'b1;
			INT <= 1'b0;
			MASK_OUT <= 8'h00;
			IN_SERVICE_OUT <= 8'h00;
			SPECIAL_MASK_OUT <= 1'b0;
			LOWEST_LEVEL_OUT <= `OCP_LOWEST_RESET;
		end else begin
			mask_q <= mask_d;
			isr_q <= isr_d;
			low_q <= low_d;
			smm_q <= smm_d;
			auto_rot_q <= auto_rot_d;
			poll_q <= poll_d;
			read_is_q <= read_is_d;
			ack_st_q <= ack_st_d;
			ack_lvl_q <= ack_lvl_d;
			DATA_OUT <= dout_d;
			DATA_OE_N <= oe_n_d;
			INT <= int_d;
			// mirrors lag the state by one cycle so every output stays a flop
			MASK_OUT <= mask_q;
			IN_SERVICE_OUT <= isr_q;
			SPECIAL_MASK_OUT <= smm_q;
			LOWEST_LEVEL_OUT <= low_q;
		end
	end

endmodule // ocp_core

`default_nettype wire

// >>> verif/ocp_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_core_monitor #(
	parameter NUM_LEVELS = 8
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic INIT_DONE,
	input wire logic AUTO_SERVICE_END,
	input wire logic [4:0] VECTOR_BASE,
	input wire logic CS_N,
	input wire logic WR_N,
	input wire logic RD_N,
	input wire logic REG_SEL,
	input wire logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE_N,
	input wire logic INT,
	input wire logic [NUM_LEVELS-1:0] MASK_OUT,
	input wire logic [NUM_LEVELS-1:0] IN_SERVICE_OUT,
	input wire logic SPECIAL_MASK_OUT,
	input wire logic [2:0] LOWEST_LEVEL_OUT
);
	logic wa_q;
	logic s_q;
	logic [7:0] d_q;
	wire logic wa = !CS_N && !WR_N;
	wire logic done = wa_q && !wa && INIT_DONE;
	wire logic cmd = done && !s_q && !d_q[4];
	wire logic [7:0] is = IN_SERVICE_OUT;
	// shadow of the byte, since the bus may move once the strobe ends
	always @(posedge CLOCK) begin
		wa_q <= RST ? 1'b0 : wa;
		if (wa) begin
			d_q <= DATA_IN;
			s_q <= REG_SEL;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	AST_MASK_LOAD: assert property (done && s_q |-> ##2 MASK_OUT == $past(d_q, 2))
		else $error("mask not loaded");
	AST_MASKED_QUIET: assert property (MASK_OUT == 8'hff && $past(MASK_OUT) == 8'hff |-> !INT)
		else $error("masked channel interrupted");
	AST_INIT_DEFAULTS: assert property (!INIT_DONE ##1 !INIT_DONE |-> ##1 MASK_OUT == 8'h00
		&& is == 8'h00 && LOWEST_LEVEL_OUT == 3'h7) else $error("defaults lost");
	AST_SPECIAL_SET: assert property (cmd && d_q[3] && !d_q[7] && d_q[6]
		|-> ##2 SPECIAL_MASK_OUT == $past(d_q[5], 2)) else $error("special mode not set");
	AST_SPECIAL_KEEP: assert property (cmd && d_q[3] && !d_q[7] && !d_q[6]
		|-> ##2 $stable(SPECIAL_MASK_OUT)[*2]) else $error("special mode moved");
	AST_NONSPEC_EOS: assert property (cmd && d_q[7:3] == 5'h04 && !SPECIAL_MASK_OUT
		&& LOWEST_LEVEL_OUT == 3'h7 |-> ##2 is == ($past(is) & ($past(is) - 8'h01)))
		else $error("wrong bit cleared");
	AST_SPEC_EOS: assert property (cmd && d_q[7:3] == 5'h0c
		|-> ##2 is == ($past(is) & ~(8'h01 << $past(d_q[2:0], 2)))) else $error("level not cleared");
	AST_ACK_VECTOR: assert property ($fell(DATA_OE_N) && $past(RD_N) |-> DATA_OUT[7:3] == VECTOR_BASE
		&& (DATA_OUT[2:0] == 3'h7 || is[DATA_OUT[2:0]])) else $error("bad vector");
	AST_AUTO_END: assert property ($rose(DATA_OE_N) && $past(RD_N, 2) && $past(RD_N, 3)
		&& AUTO_SERVICE_END && is == 8'h02 |-> ##1 is == 8'h00) else $error("no auto end");
	cover property (done && s_q);
	cover property ($fell(DATA_OE_N) && $past(RD_N));
	cover property ($rose(SPECIAL_MASK_OUT));
endmodule // ocp_core_monitor
bind ocp_core ocp_core_monitor #(.NUM_LEVELS(NUM_LEVELS)) u_mon (.CLOCK(CLOCK), .RST(RST),
	.INIT_DONE(INIT_DONE), .AUTO_SERVICE_END(AUTO_SERVICE_END), .VECTOR_BASE(VECTOR_BASE),
	.CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N), .REG_SEL(REG_SEL), .DATA_IN(DATA_IN),
	.DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .INT(INT), .MASK_OUT(MASK_OUT),
	.IN_SERVICE_OUT(IN_SERVICE_OUT), .SPECIAL_MASK_OUT(SPECIAL_MASK_OUT),
	.LOWEST_LEVEL_OUT(LOWEST_LEVEL_OUT));
`default_nettype wire

// >>> verif/ocp_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module ocp_cpu_model (
	input wire logic clock,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	output logic ack_n
);
	initial ack_n = 1'b1;
	// two strobes per acknowledge; gap makes the processor slow or prompt
	task automatic ack(input int gap, output logic [7:0] vec);
		@(posedge clock);
		ack_n <= 1'b0;
		repeat (2) @(posedge clock);
		ack_n <= 1'b1;
		repeat (gap) @(posedge clock);
		ack_n <= 1'b0;
		repeat (3) @(posedge clock);
		vec = data_oe_n ? 8'hxx : data_out;
		ack_n <= 1'b1;
	endtask
endmodule // ocp_cpu_model
`default_nettype wire

// >>> verif/test_ocp_core.sv
`timescale 1ns/10ps
`default_nettype none
module test_ocp_core;
	logic clock, rst, init_done, auto_end, cs_n, wr_n, rd_n, sel, ack_n, irq, oe_n, special_mask_setting;
	logic [4:0] vbase;
	logic [7:0] din, dout, req, mask, isr, v;
	logic [2:0] lowest;
	logic [7:0] sm_cmd [4] = '{8'h68, 8'h08, 8'h48, 8'h28};
	logic [7:0] sm_exp [4] = '{8'h01, 8'h01, 8'h00, 8'h00};
	int failures, checked;
	ocp_core dut (.CLOCK(clock), .RST(rst), .INIT_DONE(init_done), .AUTO_SERVICE_END(auto_end),
		.VECTOR_BASE(vbase), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .REG_SEL(sel), .DATA_IN(din),
		.ACK_N(ack_n), .REQ(req), .DATA_OUT(dout), .DATA_OE_N(oe_n), .INT(irq), .MASK_OUT(mask),
		.IN_SERVICE_OUT(isr), .SPECIAL_MASK_OUT(special_mask_setting), .LOWEST_LEVEL_OUT(lowest));
	ocp_cpu_model cpu (.clock(clock), .data_out(dout), .data_oe_n(oe_n), .ack_n(ack_n));
	// free running system clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic summarize();
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// released data lines show the inverse so stale bytes cannot pass
	task automatic wr(input logic s, input logic [7:0] d);
		@(posedge clock);
		{cs_n, wr_n, sel, din} <= {2'b00, s, d};
		repeat (2) @(posedge clock);
		{cs_n, wr_n, din} <= {2'b11, ~d};
		repeat (4) @(posedge clock);
	endtask
	task automatic rd(input logic s, output logic [7:0] r);
		@(posedge clock);
		{cs_n, rd_n, sel} <= {2'b00, s};
		repeat (3) @(posedge clock);
		r = oe_n ? 8'hxx : dout;
		{cs_n, rd_n} <= 2'b11;
		repeat (3) @(posedge clock);
	endtask
	// main sequence
	initial begin
		{failures, checked} = 0;
		{rst, init_done, auto_end, cs_n, wr_n, rd_n, sel} = 7'b1001110;
		{vbase, din, req} = {5'h15, 16'h0000};
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		init_done <= 1'b1;
		wr(1'b1, 8'ha5);
		rd(1'b1, v);
		chk(v, 8'ha5);
		wr(1'b1, 8'hff);
		req <= 8'hff;
		repeat (4) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		wr(1'b1, 8'hf7);
		chk({7'h00, irq}, 8'h01);
		cpu.ack(1, v);
		chk(v, {vbase, 3'h3});
		repeat (3) @(posedge clock);
		chk(isr, 8'h08);
		chk({7'h00, irq}, 8'h00);
		wr(1'b1, 8'hf3);
		chk({7'h00, irq}, 8'h01);
		cpu.ack(3, v);
		chk(v, {vbase, 3'h2});
		wr(1'b0, 8'h0b);
		rd(1'b0, v);
		chk(v, 8'h0c);
		wr(1'b0, 8'h20);
		chk(isr, 8'h08);
		wr(1'b0, 8'h63);
		chk(isr, 8'h00);
		foreach (sm_cmd[i]) begin
			wr(1'b0, sm_cmd[i]);
			chk({7'h00, special_mask_setting}, sm_exp[i]);
		end
		wr(1'b1, 8'h00);
		wr(1'b0, 8'hc3);
		chk({5'h00, lowest}, 8'h03);
		req <= 8'h11;
		repeat (3) @(posedge clock);
		cpu.ack(1, v);
		chk(v, {vbase, 3'h4});
		wr(1'b0, 8'h64);
		chk(isr, 8'h00);
		wr(1'b0, 8'hc7);
		auto_end <= 1'b1;
		req <= 8'h02;
		repeat (3) @(posedge clock);
		cpu.ack(1, v);
		chk(v, {vbase, 3'h1});
		repeat (3) @(posedge clock);
		chk(isr, 8'h00);
		// automatic rotation: the level just ended becomes the lowest
		wr(1'b0, 8'h80);
		cpu.ack(1, v);
		chk(v, {vbase, 3'h1});
		repeat (3) @(posedge clock);
		chk({5'h00, lowest}, 8'h01);
		chk(isr, 8'h00);
		auto_end <= 1'b0;
		wr(1'b0, 8'h00);
		wr(1'b0, 8'hc7);
		// poll answers with the top request and puts it in service
		wr(1'b0, 8'h0c);
		rd(1'b0, v);
		chk(v, 8'h81);
		chk(isr, 8'h02);
		wr(1'b0, 8'ha0);
		chk(isr, 8'h00);
		chk({5'h00, lowest}, 8'h01);
		init_done <= 1'b0;
		wr(1'b1, 8'h55);
		chk(mask, 8'h00);
		chk({7'h00, irq}, 8'h00);
		summarize();
	end
	// watchdog against a hung handshake
	initial begin
		#100000;
		failures++;
		summarize();
	end
endmodule // test_ocp_core
`default_nettype wire
